// file: rtl/port_logical_device_config.sv
// Configuration bank for the printer port and the infrared serial unit.
//
// Operation
// - Printer configuration resets to F2h.
// - Extended access off ignores runtime 403h-405h.
// - Extended access on serves runtime 403h-405h.
// - Printer power bit low stops port clock.
// - Printer power bit high runs port clock while printer active.
// - Float enable plus inactive floats output pins.
// - Infrared transmit low whenever serial unit inactive.
// - Serial configuration resets to 02h.
// - Bank enable low ignores banked register accesses.
// - Busy bit reads transfer in progress.
// - Serial power low stops clock, defaults outputs.
// - Only activation blocks serial runtime register access.
// - Serial power bit high enables serial clock while active.
// - Serial activate resets 00h, gated by globals.
// - Base high resets 02h, bits 7-3 zero.
// - Base low resets F8h, bits 2-0 zero.
// - Interrupt number and wake register resets 03h.
// - Interrupt type resets 03h, bit 1 writable.
// - Channel selects reset 04h, both writable.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module port_logical_device_config (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Configuration register port
  input wire logic [port_logical_device_config_pkg::ADDR_W-1:0] address_i,
  input wire logic [port_logical_device_config_pkg::DATA_W-1:0] write_data_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [port_logical_device_config_pkg::DATA_W-1:0] read_data_o,
  // Global configuration and printer activation
  input wire logic [port_logical_device_config_pkg::DATA_W-1:0] global_config_one_i,
  input wire logic [port_logical_device_config_pkg::DATA_W-1:0] global_config_six_i,
  input wire logic printer_active_i,
  // Printer runtime access
  input wire logic [port_logical_device_config_pkg::RT_OFFSET_W-1:0] printer_rt_offset_i,
  input wire logic printer_rt_read_i,
  input wire logic printer_rt_write_i,
  output logic printer_ext_read_o,
  output logic printer_ext_write_o,
  // Printer power and pins
  output logic printer_clock_enable_o,
  output logic printer_pins_float_o,
  // Serial runtime access
  input wire logic serial_rt_read_i,
  input wire logic serial_rt_write_i,
  input wire logic serial_bank_read_i,
  input wire logic serial_bank_write_i,
  output logic serial_rt_read_o,
  output logic serial_rt_write_o,
  output logic serial_bank_read_o,
  output logic serial_bank_write_o,
  // Serial status and power
  input wire logic serial_busy_i,
  input wire logic call_alert_input_i,
  input wire logic infrared_tx_data_i,
  output logic serial_active_o,
  output logic serial_clock_enable_o,
  output logic serial_outputs_default_o,
  output logic serial_pins_float_o,
  output logic infrared_transmit_pin_o,
  output logic call_alert_wake_o,
  // Serial resources
  output logic [port_logical_device_config_pkg::BASE_W-1:0] serial_base_o,
  output logic [port_logical_device_config_pkg::IRQ_NUMBER_W-1:0] serial_irq_number_o,
  output logic serial_irq_level_o,
  output logic serial_irq_high_o,
  output logic [port_logical_device_config_pkg::DATA_W-1:0] serial_rx_channel_o,
  output logic [port_logical_device_config_pkg::DATA_W-1:0] serial_tx_channel_o
);
  import port_logical_device_config_pkg::*;

  logic [DATA_W-1:0] printer_config_reg;
  logic [DATA_W-1:0] serial_config_reg;
  logic [DATA_W-1:0] serial_activate_reg;
  logic [DATA_W-1:0] serial_base_high_reg;
  logic [DATA_W-1:0] serial_base_low_reg;
  logic [DATA_W-1:0] serial_irq_number_wake_reg;
  logic [DATA_W-1:0] serial_irq_type_reg;
  logic [DATA_W-1:0] serial_rx_channel_select_reg;
  logic [DATA_W-1:0] serial_tx_channel_select_reg;
  logic [DATA_W-1:0] read_data_reg;
  logic [DATA_W-1:0] read_data_next;
  logic [DATA_W-1:0] serial_config_view;
  logic call_alert_wake_reg;
  logic call_alert_wake_next;
  logic [DATA_W-1:0] index;
  logic unit_serial;
  logic wr_printer_config;
  logic wr_serial_config;
  logic wr_activate;
  logic wr_base_high;
  logic wr_base_low;
  logic wr_irq_number;
  logic wr_irq_type;
  logic wr_rx_channel;
  logic wr_tx_channel;
  logic serial_effective_active;
  logic ext_offset_hit;

  // Address bit eight picks the unit, so both units share one index map.
  assign index = address_i[DATA_W-1:0];
  assign unit_serial = address_i[ADDR_UNIT_BIT] == UNIT_SERIAL;

  // Write decode: one strobe per register of the selected unit.
  // A write to an index that neither unit maps raises no strobe and is lost.
  always_comb begin
    wr_printer_config = 1'h0;
    wr_serial_config = 1'h0;
    wr_activate = 1'h0;
    wr_base_high = 1'h0;
    wr_base_low = 1'h0;
    wr_irq_number = 1'h0;
    wr_irq_type = 1'h0;
    wr_rx_channel = 1'h0;
    wr_tx_channel = 1'h0;
    if (write_i && !unit_serial) begin
      wr_printer_config = index == IDX_PORT_CONFIG;
    end
    if (write_i && unit_serial) begin
      case (index)
        IDX_PORT_CONFIG: begin
          wr_serial_config = 1'h1;
        end
        IDX_ACTIVATE: begin
          wr_activate = 1'h1;
        end
        IDX_BASE_HIGH: begin
          wr_base_high = 1'h1;
        end
        IDX_BASE_LOW: begin
          wr_base_low = 1'h1;
        end
        IDX_IRQ_NUMBER: begin
          wr_irq_number = 1'h1;
        end
        IDX_IRQ_TYPE: begin
          wr_irq_type = 1'h1;
        end
        IDX_RX_CHANNEL: begin
          wr_rx_channel = 1'h1;
        end
        IDX_TX_CHANNEL: begin
          wr_tx_channel = 1'h1;
        end
        default: begin
          wr_serial_config = 1'h0;
        end
      endcase
    end
  end

  // Software is expected to write ones to the top three bits; the value is
  // stored as written so a misbehaving driver can be seen on read back.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      printer_config_reg <= PRINTER_CONFIG_RESET;
    end else if (wr_printer_config) begin
      printer_config_reg <= write_data_i;
    end
  end

  // Reserved bits and the live busy bit are not stored, so they cannot go stale.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      serial_config_reg <= SERIAL_CONFIG_RESET;
    end else if (wr_serial_config) begin
      serial_config_reg <= write_data_i & SERIAL_CONFIG_MASK;
    end
  end

  // Only the enable bit is kept; the other bits read back as zero.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      serial_activate_reg <= ACTIVATE_RESET;
    end else if (wr_activate) begin
      serial_activate_reg <= write_data_i & ACTIVATE_MASK;
    end
  end

  // The read-only upper address bits are dropped as they are written.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      serial_base_high_reg <= BASE_HIGH_RESET;
    end else if (wr_base_high) begin
      serial_base_high_reg <= write_data_i & BASE_HIGH_MASK;
    end
  end

  // Dropping the low three bits keeps the base aligned to eight bytes.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      serial_base_low_reg <= BASE_LOW_RESET;
    end else if (wr_base_low) begin
      serial_base_low_reg <= write_data_i & BASE_LOW_MASK;
    end
  end

  // The low bits pick the interrupt line and bit four arms the call-alert wake.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      serial_irq_number_wake_reg <= IRQ_NUMBER_RESET;
    end else if (wr_irq_number) begin
      serial_irq_number_wake_reg <= write_data_i;
    end
  end

  // Only the polarity bit is stored; the level bit is fixed at one.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      serial_irq_type_reg <= IRQ_TYPE_RESET;
    end else if (wr_irq_type) begin
      serial_irq_type_reg <= (write_data_i & IRQ_TYPE_MASK) | IRQ_TYPE_FIXED;
    end
  end

  // Channel codes are stored whole; no check against other units is made here.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      serial_rx_channel_select_reg <= CHANNEL_RESET;
    end else if (wr_rx_channel) begin
      serial_rx_channel_select_reg <= write_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      serial_tx_channel_select_reg <= CHANNEL_RESET;
    end else if (wr_tx_channel) begin
      serial_tx_channel_select_reg <= write_data_i;
    end
  end

  // The busy bit is live status, never stored.
  // The host sees the value sampled at the edge that takes the read strobe.
  always_comb begin
    serial_config_view = serial_config_reg;
    serial_config_view[SER_BUSY_BIT] = serial_busy_i;
  end

  // Read mux: unmapped indices of either unit return zero.
  // Zero rather than stale data keeps probing software well behaved.
  always_comb begin
    read_data_next = READ_UNMAPPED;
    if (!unit_serial) begin
      case (index)
        IDX_PORT_CONFIG: begin
          read_data_next = printer_config_reg;
        end
        default: begin
          read_data_next = READ_UNMAPPED;
        end
      endcase
    end else begin
      case (index)
        IDX_PORT_CONFIG: begin
          read_data_next = serial_config_view;
        end
        IDX_ACTIVATE: begin
          read_data_next = serial_activate_reg;
        end
        IDX_BASE_HIGH: begin
          read_data_next = serial_base_high_reg;
        end
        IDX_BASE_LOW: begin
          read_data_next = serial_base_low_reg;
        end
        IDX_IRQ_NUMBER: begin
          read_data_next = serial_irq_number_wake_reg;
        end
        IDX_IRQ_TYPE: begin
          read_data_next = serial_irq_type_reg;
        end
        IDX_RX_CHANNEL: begin
          read_data_next = serial_rx_channel_select_reg;
        end
        IDX_TX_CHANNEL: begin
          read_data_next = serial_tx_channel_select_reg;
        end
        default: begin
          read_data_next = READ_UNMAPPED;
        end
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      read_data_reg <= READ_UNMAPPED;
    end else if (read_i) begin
      read_data_reg <= read_data_next;
    end else begin
      read_data_reg <= READ_UNMAPPED;
    end
  end

  assign read_data_o = read_data_reg;

  // Activation needs the local bit and both global enables.
  // The global enables come in as levels; this block does not store them.
  assign serial_effective_active = serial_activate_reg[ACTIVATE_BIT] &&
    global_config_one_i[GLOBAL_ONE_ENABLE_BIT] &&
    global_config_six_i[GLOBAL_SIX_SERIAL_BIT];
  assign serial_active_o = serial_effective_active;

  // Printer extended runtime window.
  // The offset is relative to the port base; the base compare happens upstream.
  assign ext_offset_hit = printer_rt_offset_i >= EXT_OFFSET_FIRST &&
    printer_rt_offset_i <= EXT_OFFSET_LAST;
  assign printer_ext_read_o = printer_rt_read_i && ext_offset_hit &&
    printer_config_reg[PRN_EXT_ACCESS_BIT];
  assign printer_ext_write_o = printer_rt_write_i && ext_offset_hit &&
    printer_config_reg[PRN_EXT_ACCESS_BIT];

  // Gating the clock leaves every register of the port intact.
  // Float is only requested here; the pad ring turns it into released pins.
  assign printer_clock_enable_o = printer_active_i &&
    printer_config_reg[CFG_POWER_BIT];
  assign printer_pins_float_o = !printer_active_i &&
    printer_config_reg[CFG_FLOAT_BIT];

  // Low power does not block register access; activation does, and the bank enable bit also gates banked access.
  assign serial_rt_read_o = serial_rt_read_i && serial_effective_active;
  assign serial_rt_write_o = serial_rt_write_i && serial_effective_active;
  assign serial_bank_read_o = serial_bank_read_i && serial_effective_active &&
    serial_config_reg[SER_BANK_ENABLE_BIT];
  assign serial_bank_write_o = serial_bank_write_i && serial_effective_active &&
    serial_config_reg[SER_BANK_ENABLE_BIT];

  // Serial power control.
  // Asleep or inactive, the port drives its default outputs.
  assign serial_clock_enable_o = serial_effective_active &&
    serial_config_reg[CFG_POWER_BIT];
  assign serial_outputs_default_o = !serial_config_reg[CFG_POWER_BIT] ||
    !serial_effective_active;
  assign serial_pins_float_o = !serial_effective_active &&
    serial_config_reg[CFG_FLOAT_BIT];

  // The transmit pin never floats; it idles low so an emitter stays dark.
  assign infrared_transmit_pin_o = serial_effective_active &&
    serial_config_reg[CFG_POWER_BIT] && infrared_tx_data_i;

  // The ring-type input still wakes the system with the serial clock off.
  // It is registered so the wake line never carries a combinational glitch.
  assign call_alert_wake_next = call_alert_input_i && serial_effective_active &&
    serial_irq_number_wake_reg[WAKE_ENABLE_BIT];

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      call_alert_wake_reg <= WAKE_RESET;
    end else begin
      call_alert_wake_reg <= call_alert_wake_next;
    end
  end

  assign call_alert_wake_o = call_alert_wake_reg;

  // Resource outputs.
  assign serial_base_o = {serial_base_high_reg, serial_base_low_reg};
  assign serial_irq_number_o = serial_irq_number_wake_reg[IRQ_NUMBER_W-1:0];
  // The level bit is fixed at one, so only the polarity follows software.
  assign serial_irq_level_o = serial_irq_type_reg[IRQ_LEVEL_BIT];
  assign serial_irq_high_o = serial_irq_type_reg[IRQ_HIGH_BIT];
  assign serial_rx_channel_o = serial_rx_channel_select_reg;
  assign serial_tx_channel_o = serial_tx_channel_select_reg;

endmodule : port_logical_device_config

`default_nettype wire

// file: rtl/port_logical_device_config_pkg.sv
// Constants shared by the printer and infrared serial configuration bank.
package port_logical_device_config_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 9;
  localparam int ADDR_UNIT_BIT = 8;
  localparam int RT_OFFSET_W = 11;
  localparam int IRQ_NUMBER_W = 4;
  localparam int BASE_W = 16;
  localparam logic UNIT_PRINTER = 1'h0;
  localparam logic UNIT_SERIAL = 1'h1;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
  localparam logic [7:0] IDX_BASE_LOW = 8'h61;
  localparam logic [7:0] IDX_IRQ_NUMBER = 8'h70;
  localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
  localparam logic [7:0] IDX_RX_CHANNEL = 8'h74;
  localparam logic [7:0] IDX_TX_CHANNEL = 8'h75;
  localparam logic [7:0] IDX_PORT_CONFIG = 8'hF0;
  localparam logic [7:0] PRINTER_CONFIG_RESET = 8'hF2;
  localparam logic [7:0] SERIAL_CONFIG_RESET = 8'h02;
  localparam logic [7:0] ACTIVATE_RESET = 8'h00;
  localparam logic [7:0] BASE_HIGH_RESET = 8'h02;
  localparam logic [7:0] BASE_LOW_RESET = 8'hF8;
  localparam logic [7:0] IRQ_NUMBER_RESET = 8'h03;
  localparam logic [7:0] IRQ_TYPE_RESET = 8'h03;
  localparam logic [7:0] CHANNEL_RESET = 8'h04;
  localparam logic [7:0] ACTIVATE_MASK = 8'h01;
  localparam logic [7:0] BASE_HIGH_MASK = 8'h07;
  localparam logic [7:0] BASE_LOW_MASK = 8'hF8;
  localparam logic [7:0] SERIAL_CONFIG_MASK = 8'h83;
  localparam logic [7:0] IRQ_TYPE_MASK = 8'h02;
  localparam logic [7:0] IRQ_TYPE_FIXED = 8'h01;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam int CFG_FLOAT_BIT = 0;
  localparam int CFG_POWER_BIT = 1;
  localparam int SER_BUSY_BIT = 2;
  localparam int PRN_EXT_ACCESS_BIT = 4;
  localparam int SER_BANK_ENABLE_BIT = 7;
  localparam int ACTIVATE_BIT = 0;
  localparam int WAKE_ENABLE_BIT = 4;
  localparam int IRQ_LEVEL_BIT = 0;
  localparam int IRQ_HIGH_BIT = 1;
  localparam logic WAKE_RESET = 1'h0;
  localparam int GLOBAL_ONE_ENABLE_BIT = 0;
  localparam int GLOBAL_SIX_SERIAL_BIT = 2;
  localparam logic [10:0] EXT_OFFSET_FIRST = 11'h403;
  localparam logic [10:0] EXT_OFFSET_LAST = 11'h405;
endpackage : port_logical_device_config_pkg

// file: verification/host_cfg_master.sv
// Host software model that runs configuration register bus cycles.
`timescale 1ns/100ps
`default_nettype none
module host_cfg_master (
  // Clock
  input wire logic clock_i,
  // Register bus
  output logic [8:0] address_o,
  output logic [7:0] write_data_o,
  output logic write_o,
  output logic read_o,
  input wire logic [7:0] read_data_i
);
  initial begin
    address_o = 9'h000;
    write_data_o = 8'h00;
    write_o = 1'b0;
    read_o = 1'b0;
  end
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 9'h0F0) begin
      v[7:5] = 3'h7;
    end
    @(posedge clock_i);
    address_o <= a;
    write_data_o <= v;
    write_o <= 1'b1;
    @(posedge clock_i);
    write_o <= 1'b0;
  endtask : wr
  // The answer stands only in the cycle after the strobe, so it is taken just past that edge.
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge clock_i);
    address_o <= a;
    read_o <= 1'b1;
    @(posedge clock_i);
    read_o <= 1'b0;
    #1;
    d = read_data_i;
  endtask : rd
endmodule : host_cfg_master
`default_nettype wire

// file: verification/port_cfg_checker_properties.sv
// Port-level checker for the printer and infrared serial configuration bank.
`timescale 1ns/100ps
`default_nettype none
module port_cfg_checker (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Observed ports
  input wire logic read_i,
  input wire logic [7:0] read_data_o,
  input wire logic [7:0] global_config_one_i,
  input wire logic [7:0] global_config_six_i,
  input wire logic printer_active_i,
  input wire logic [10:0] printer_rt_offset_i,
  input wire logic printer_rt_read_i,
  input wire logic printer_ext_read_o,
  input wire logic printer_clock_enable_o,
  input wire logic printer_pins_float_o,
  input wire logic serial_rt_read_i,
  input wire logic serial_bank_read_i,
  input wire logic serial_rt_read_o,
  input wire logic serial_bank_read_o,
  input wire logic call_alert_input_i,
  input wire logic serial_active_o,
  input wire logic serial_clock_enable_o,
  input wire logic serial_outputs_default_o,
  input wire logic infrared_transmit_pin_o,
  input wire logic call_alert_wake_o,
  input wire logic [15:0] serial_base_o
);
  default clocking dclk @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  sequence no_read;
    !read_i;
  endsequence
  sequence ext_window;
    printer_rt_read_i && printer_rt_offset_i >= 11'h403 && printer_rt_offset_i <= 11'h405;
  endsequence
  AST_EXT_GATE: assert property (printer_ext_read_o |-> ext_window)
    else $error("printer extended read passed outside its window");
  AST_BANK_GATE: assert property (serial_bank_read_o |-> serial_bank_read_i && serial_active_o)
    else $error("banked serial read passed while not allowed");
  AST_RT_ACCESS: assert property (serial_rt_read_o == (serial_rt_read_i && serial_active_o))
    else $error("serial runtime read gate wrong");
  AST_IR_LOW: assert property (!serial_active_o |-> !infrared_transmit_pin_o)
    else $error("infrared transmit not low while inactive");
  AST_SER_POWER: assert property (serial_outputs_default_o == !serial_clock_enable_o)
    else $error("serial default outputs disagree with clock enable");
  AST_SER_CLK_ACT: assert property (serial_clock_enable_o |-> serial_active_o)
    else $error("serial clock enabled while inactive");
  AST_ACT_GLOBAL: assert property (serial_active_o |-> global_config_one_i[0] && global_config_six_i[2])
    else $error("serial active without global enables");
  AST_BASE_ALIGN: assert property (serial_base_o[15:11] == 5'h00 && serial_base_o[2:0] == 3'h0)
    else $error("serial base has read-only bits set");
  AST_PRN_POWER: assert property (printer_clock_enable_o |-> printer_active_i && !printer_pins_float_o)
    else $error("printer clock or float wrong for activation");
  AST_READ_IDLE: assert property (no_read |=> read_data_o == 8'h00)
    else $error("read data outside the answer cycle");
  AST_WAKE: assert property (call_alert_wake_o |-> $past(call_alert_input_i) && $past(serial_active_o))
    else $error("wake without a call alert on an active unit");
endmodule : port_cfg_checker
bind port_logical_device_config port_cfg_checker chk (.*);
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the printer and infrared serial configuration bank.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [8:0] address_i;
  logic [7:0] write_data_i, read_data_o, global_config_one_i, global_config_six_i, rv;
  logic write_i, read_i, printer_active_i, printer_rt_read_i, printer_rt_write_i;
  logic [10:0] printer_rt_offset_i;
  logic printer_ext_read_o, printer_ext_write_o, printer_clock_enable_o, printer_pins_float_o;
  logic serial_rt_read_i, serial_rt_write_i, serial_bank_read_i, serial_bank_write_i;
  logic serial_rt_read_o, serial_rt_write_o, serial_bank_read_o, serial_bank_write_o;
  logic serial_busy_i, call_alert_input_i, infrared_tx_data_i, serial_active_o;
  logic serial_clock_enable_o, serial_outputs_default_o, serial_pins_float_o;
  logic infrared_transmit_pin_o, call_alert_wake_o, serial_irq_level_o, serial_irq_high_o;
  logic [15:0] serial_base_o;
  logic [3:0] serial_irq_number_o;
  logic [7:0] serial_rx_channel_o, serial_tx_channel_o;
  int num_errors = 0;
  int n_compared = 0;
  port_logical_device_config dut (.*);
  host_cfg_master host (.clock_i(clock_i), .address_o(address_i), .write_data_o(write_data_i),
    .write_o(write_i), .read_o(read_i), .read_data_i(read_data_o));
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic report_and_stop;
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk_rd(input logic [8:0] a, input logic [7:0] e);
    host.rd(a, rv);
    `CHK(rv, e)
  endtask : chk_rd
  task automatic t_reset_values;
    chk_rd(9'h0F0, 8'hF2);
    chk_rd(9'h1F0, 8'h02);
    chk_rd(9'h130, 8'h00);
    chk_rd(9'h160, 8'h02);
    chk_rd(9'h161, 8'hF8);
    chk_rd(9'h170, 8'h03);
    chk_rd(9'h171, 8'h03);
    chk_rd(9'h174, 8'h04);
    chk_rd(9'h175, 8'h04);
    `CHK(serial_base_o, 16'h02F8)
  endtask : t_reset_values
  task automatic t_masks;
    logic [8:0] a [7] = '{9'h130, 9'h160, 9'h161, 9'h170, 9'h171, 9'h174, 9'h175};
    logic [7:0] hi [7] = '{8'h01, 8'h07, 8'hF8, 8'hFF, 8'h03, 8'hFF, 8'hFF};
    logic [7:0] lo [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) begin
      host.wr(a[i], 8'hFF);
      chk_rd(a[i], hi[i]);
      host.wr(a[i], 8'h00);
      chk_rd(a[i], lo[i]);
    end
    host.wr(9'h140, 8'hFF);
    chk_rd(9'h140, 8'h00);
    host.wr(9'h160, 8'h01);
    host.wr(9'h161, 8'h2F);
    host.wr(9'h171, 8'h02);
    host.wr(9'h174, 8'h01);
    host.wr(9'h175, 8'h05);
    host.wr(9'h170, 8'h1B);
    #1;
    `CHK(serial_irq_number_o, 4'hB)
    `CHK(serial_base_o, 16'h0128)
    `CHK({serial_irq_high_o, serial_irq_level_o}, 2'h3)
    `CHK({serial_rx_channel_o, serial_tx_channel_o}, 16'h0105)
  endtask : t_masks
  task automatic t_busy;
    @(posedge clock_i);
    serial_busy_i <= 1'b1;
    chk_rd(9'h1F0, 8'h06);
    @(posedge clock_i);
    serial_busy_i <= 1'b0;
    chk_rd(9'h1F0, 8'h02);
  endtask : t_busy
  task automatic t_printer;
    @(posedge clock_i);
    printer_rt_read_i <= 1'b1;
    printer_rt_write_i <= 1'b1;
    printer_active_i <= 1'b1;
    for (int o = 'h402; o <= 'h406; o++) begin
      @(posedge clock_i);
      printer_rt_offset_i <= o[10:0];
      #1;
      `CHK(printer_ext_read_o, o != 'h402 && o != 'h406)
      `CHK(printer_ext_write_o, o != 'h402 && o != 'h406)
    end
    `CHK(printer_clock_enable_o, 1'b1)
    host.wr(9'h0F0, 8'h0D);
    chk_rd(9'h0F0, 8'hED);
    @(posedge clock_i);
    printer_rt_offset_i <= 11'h404;
    #1;
    `CHK({printer_ext_read_o, printer_ext_write_o}, 2'h0)
    `CHK(printer_clock_enable_o, 1'b0)
    `CHK(printer_pins_float_o, 1'b0)
    @(posedge clock_i);
    printer_active_i <= 1'b0;
    #1;
    `CHK(printer_pins_float_o, 1'b1)
  endtask : t_printer
  task automatic t_serial;
    @(posedge clock_i);
    global_config_one_i <= 8'h01;
    global_config_six_i <= 8'h04;
    serial_rt_read_i <= 1'b1;
    serial_bank_read_i <= 1'b1;
    serial_rt_write_i <= 1'b1;
    serial_bank_write_i <= 1'b1;
    infrared_tx_data_i <= 1'b1;
    host.wr(9'h130, 8'h01);
    #1;
    `CHK(serial_active_o, 1'b1)
    `CHK({serial_clock_enable_o, infrared_transmit_pin_o}, 2'h3)
    `CHK(serial_bank_read_o, 1'b0)
    `CHK(serial_bank_write_o, 1'b0)
    host.wr(9'h1F0, 8'h81);
    host.wr(9'h170, 8'h10);
    #1;
    `CHK(serial_bank_read_o, 1'b1)
    `CHK(serial_bank_write_o, 1'b1)
    `CHK({serial_clock_enable_o, serial_outputs_default_o}, 2'h1)
    `CHK(serial_rt_read_o, 1'b1)
    `CHK(serial_rt_write_o, 1'b1)
    chk_rd(9'h1F0, 8'h81);
    @(posedge clock_i);
    call_alert_input_i <= 1'b1;
    @(posedge clock_i);
    #1;
    `CHK(call_alert_wake_o, 1'b1)
    // Power back on with transmit data high, so a low pin can only come from deactivation.
    host.wr(9'h1F0, 8'h03);
    @(posedge clock_i);
    global_config_six_i <= 8'h00;
    #1;
    `CHK(serial_active_o, 1'b0)
    `CHK(infrared_transmit_pin_o, 1'b0)
    `CHK(serial_pins_float_o, 1'b1)
    `CHK(serial_rt_read_o, 1'b0)
    `CHK(serial_rt_write_o, 1'b0)
  endtask : t_serial
  initial begin
    global_config_one_i = 8'h00;
    global_config_six_i = 8'h00;
    {printer_active_i, printer_rt_read_i, printer_rt_write_i} = 3'h0;
    printer_rt_offset_i = 11'h000;
    {serial_rt_read_i, serial_rt_write_i, serial_bank_read_i, serial_bank_write_i} = 4'h0;
    {serial_busy_i, call_alert_input_i, infrared_tx_data_i} = 3'h0;
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_reset_values;
    t_masks;
    t_busy;
    t_printer;
    t_serial;
    report_and_stop;
  end
  initial begin
    #200000;
    num_errors++;
    report_and_stop;
  end
endmodule : tb
`default_nettype wire
